// ### rtl/lhd_pkg.sv
// Constants and types of the host command decoder
// Operation
// RL1: Bytes 20h-27h are one-byte view commands
// RL2: Erase timer acts only outside text modes
// RL3: 23h/27h graze view, 21h/25h alternate view
// RL4: 20h timer on, 24h off, no mode
// RL5: Timer on/off leaves display mode alone
// RL6: Two-byte writes: select byte then value
// RL7: Config: 00 default, 02 mono, 0c lock
// RL8: Standard bit moves extraction to line 22
// RL9: Display: c0 default, shadow, 15 lines, e0
// RL10: Horizontal position sets box position
// RL11: Top position bit makes box blue
// RL12: Text position: base row, row count
// RL13: Filter 00 none, 1F every class
// RL14: Each filter bit enables one class
// RL15: Filter values 41, 28, 9e as given
// RL16: No packets before a filter write
// RL17: Mask 00 clears all interrupt bits
// RL18: Host polls ready before each byte
// RL19: Acknowledge write address 28h
// RL20: Status shows ready, field and lock
// RL21: Caption/text command ends view mode
// RL22: Erase caption after sixteen idle seconds
// RL23: Ready low while a byte is processed
package lhd_pkg;
  localparam logic [7:0] DEV_WR_ADDR = 8'h28;
  localparam logic [7:0] DEV_RD_ADDR = 8'h29;
  localparam logic [3:0] CPTX_NIB = 4'h1;
  localparam logic [4:0] VIEW_TOP = 5'h04;
  localparam logic [4:0] SEL_TOP = 5'h18;
  localparam logic [1:0] VIEW_NONE = 2'h0;
  localparam logic [1:0] VIEW_ALT = 2'h1;
  localparam logic [1:0] VIEW_GRAZE = 2'h3;
  localparam int VIEW_OFF_BIT = 2;
  localparam int CPTX_CAP_BIT = 2;
  localparam int CPTX_DEC_BIT = 0;
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_DISP = 3'h1;
  localparam logic [2:0] REG_HPOS = 3'h2;
  localparam logic [2:0] REG_TPOS = 3'h3;
  localparam logic [2:0] REG_FILT = 3'h5;
  localparam logic [2:0] REG_IMSK = 3'h7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] DISP_RST = 8'hC0;
  localparam logic [7:0] HPOS_RST = 8'h26;
  localparam logic [7:0] TPOS_RST = 8'hFF;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [7:0] IMSK_RST = 8'h00;
  localparam int CFG_TVS_BIT = 0;
  localparam int CFG_MONO_BIT = 1;
  localparam int CFG_VLK_BIT = 2;
  localparam int CFG_HLK_BIT = 3;
  localparam int DISP_SHADOW_BIT = 0;
  localparam int DISP_15L_BIT = 1;
  localparam int DISP_ENH_OFF_BIT = 5;
  localparam int HPOS_BLUE_BIT = 7;
  localparam int SS_RDY_BIT = 7;
  localparam int SS_IRQ_BIT = 3;
  localparam int SS_FLD_BIT = 1;
  localparam int SS_LOCK_BIT = 0;
  localparam logic [4:0] LINE_NTSC = 5'h15;
  localparam logic [4:0] LINE_PAL = 5'h16;
  localparam longint CLK_HZ = 40000000;
  localparam longint ERASE_TIME_S = 16;
  localparam longint ERASE_CYCLES = ERASE_TIME_S * CLK_HZ;
  localparam int ERASE_CNT_W = 30;
  localparam logic [3:0] PROC_CYCLES = 4'h4;
  typedef enum logic [1:0] {MODE_CAPTION, MODE_TEXT, MODE_GRAZE, MODE_ALT} lhd_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_READ} lhd_state_t;
endpackage

// ### rtl/lhd_erase_timer.sv
// Idle timer that erases the caption after a quiet interval
`timescale 1ns/1ps
module lhd_erase_timer #(
  parameter int CNT_W = lhd_pkg::ERASE_CNT_W,
  parameter longint CYCLES = lhd_pkg::ERASE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic restart,
  output logic erase_pulse
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  logic [CNT_W-1:0] cnt_ff;
  logic hit;

  assign hit = run && !restart && (cnt_ff == LAST);

  ////////////////////////////////////////////////////////////////
  // Count quiet cycles, restart on new caption data
  always_ff @(posedge clock) begin
    if (sys_rst || !run || restart || hit) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1; // [RL22]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      erase_pulse <= 1'b0;
    end else begin
      erase_pulse <= hit; // [RL22]
    end
  end
endmodule

// ### rtl/lhd_decoder.sv
// Host command decoder of the caption and data-service decoder
`timescale 1ns/1ps
module lhd_decoder #(
  parameter longint ERASE_CYCLES = lhd_pkg::ERASE_CYCLES,
  parameter logic [3:0] PROC_CYCLES = lhd_pkg::PROC_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_stop,
  input wire logic [7:0] rx_byte,
  output logic rx_ack,
  output logic ready_flag,
  output logic [7:0] serial_status,
  input wire logic field_indicator,
  input wire logic video_locked,
  input wire logic caption_data_in,
  input wire logic [7:0] irq_events,
  output logic irq_request,
  output lhd_pkg::lhd_mode_t display_mode,
  output logic xds_graze_view,
  output logic xds_alt_view,
  output logic decoder_on,
  output logic erase_timer_on,
  output logic caption_erase,
  output logic tv_standard_select,
  output logic mono_select,
  output logic vertical_lock_source,
  output logic horizontal_lock_source,
  output logic [4:0] vbi_line,
  output logic drop_shadow,
  output logic rows_15_lines,
  output logic enhanced_caption_mode,
  output logic [6:0] box_position,
  output logic box_blue,
  output logic [3:0] text_base_row,
  output logic [3:0] text_row_count,
  output logic [7:0] xds_class_enable,
  output logic xds_recovery_on,
  output logic [7:0] int_mask,
  output logic [7:0] last_command
);
  lhd_pkg::lhd_state_t state_ff;
  lhd_pkg::lhd_state_t nxt_state;
  lhd_pkg::lhd_mode_t mode_ff;
  logic [3:0] busy_ff;
  logic [2:0] sel_ff;
  logic [7:0] cfg_ff;
  logic [7:0] disp_ff;
  logic [7:0] hpos_ff;
  logic [7:0] tpos_ff;
  logic [7:0] filt_ff;
  logic [7:0] imsk_ff;
  logic filt_seen_ff;
  logic timer_on_ff;
  logic dec_on_ff;
  logic irq_ff;
  logic [7:0] status_ff;
  logic [7:0] class_en_ff;
  logic [4:0] line_ff;
  logic [7:0] last_cmd_ff;
  logic ready;
  logic addr_hit;
  logic cmd_take;
  logic data_take;
  logic is_cptx;
  logic is_view;
  logic is_sel;
  logic erase_run;
  logic erase_hit;

  ////////////////////////////////////////////////////////////////
  // Byte classification and handshake
  assign ready = (busy_ff == 4'h0);
  assign addr_hit = (rx_byte == lhd_pkg::DEV_WR_ADDR) || (rx_byte == lhd_pkg::DEV_RD_ADDR);
  assign cmd_take = rx_valid && !rx_first && ready && (state_ff == lhd_pkg::ST_CMD);
  assign data_take = rx_valid && !rx_first && ready && (state_ff == lhd_pkg::ST_DATA);
  assign is_cptx = (rx_byte[7:4] == lhd_pkg::CPTX_NIB);
  assign is_view = (rx_byte[7:3] == lhd_pkg::VIEW_TOP); // [RL1]
  assign is_sel = (rx_byte[7:3] == lhd_pkg::SEL_TOP); // [RL6]

  always_comb begin
    rx_ack = 1'b0;
    if (rx_valid && rx_first) begin
      rx_ack = addr_hit; // [RL19]
    end else if (cmd_take || data_take) begin
      rx_ack = 1'b1;
    end
  end

  assign ready_flag = ready; // [RL23]

  ////////////////////////////////////////////////////////////////
  // Transfer sequencing
  always_comb begin
    nxt_state = state_ff;
    if (rx_valid && rx_first) begin
      if (rx_byte == lhd_pkg::DEV_WR_ADDR) begin
        nxt_state = lhd_pkg::ST_CMD; // [RL19]
      end else if (rx_byte == lhd_pkg::DEV_RD_ADDR) begin
        nxt_state = lhd_pkg::ST_READ;
      end else begin
        nxt_state = lhd_pkg::ST_IDLE;
      end
    end else if (rx_stop) begin
      nxt_state = lhd_pkg::ST_IDLE;
    end else begin
      unique case (state_ff)
        lhd_pkg::ST_IDLE: nxt_state = lhd_pkg::ST_IDLE;
        lhd_pkg::ST_READ: nxt_state = lhd_pkg::ST_READ;
        lhd_pkg::ST_CMD: begin
          if (cmd_take && is_sel) begin
            nxt_state = lhd_pkg::ST_DATA; // [RL6]
          end
        end
        lhd_pkg::ST_DATA: begin
          if (data_take) begin
            nxt_state = lhd_pkg::ST_CMD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= lhd_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_ff <= 3'h0;
    end else if (cmd_take && is_sel) begin
      sel_ff <= rx_byte[2:0]; // [RL6]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Busy window after each accepted command or data byte
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_ff <= 4'h0;
    end else if (cmd_take || data_take) begin
      busy_ff <= PROC_CYCLES; // [RL23]
    end else if (!ready) begin
      busy_ff <= busy_ff - 4'h1; // [RL23]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_cmd_ff <= 8'h00;
    end else if (cmd_take) begin
      last_cmd_ff <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Display mode and decoder switch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_ff <= lhd_pkg::MODE_CAPTION;
    end else if (cmd_take && is_cptx) begin
      if (rx_byte[lhd_pkg::CPTX_CAP_BIT]) begin
        mode_ff <= lhd_pkg::MODE_CAPTION; // [RL21]
      end else begin
        mode_ff <= lhd_pkg::MODE_TEXT; // [RL21]
      end
    end else if (cmd_take && is_view) begin
      if (rx_byte[1:0] == lhd_pkg::VIEW_GRAZE) begin
        mode_ff <= lhd_pkg::MODE_GRAZE; // [RL3]
      end else if (rx_byte[1:0] == lhd_pkg::VIEW_ALT) begin
        mode_ff <= lhd_pkg::MODE_ALT; // [RL3]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dec_on_ff <= 1'b0;
    end else if (cmd_take && is_cptx) begin
      dec_on_ff <= rx_byte[lhd_pkg::CPTX_DEC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Erase timer switch and timer instance
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      timer_on_ff <= 1'b0;
    end else if (cmd_take && is_view) begin
      timer_on_ff <= !rx_byte[lhd_pkg::VIEW_OFF_BIT]; // [RL3] [RL4] [RL5]
    end
  end

  assign erase_run = timer_on_ff && (mode_ff != lhd_pkg::MODE_TEXT); // [RL2]

  lhd_erase_timer #(
    .CNT_W(lhd_pkg::ERASE_CNT_W),
    .CYCLES(ERASE_CYCLES)
  ) u_erase (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(erase_run),
    .restart(caption_data_in),
    .erase_pulse(erase_hit)
  );

  assign caption_erase = erase_hit; // [RL22]

  ////////////////////////////////////////////////////////////////
  // Configuration register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_ff <= lhd_pkg::CFG_RST;
    end else if (data_take && (sel_ff == lhd_pkg::REG_CFG)) begin
      cfg_ff <= rx_byte; // [RL7]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_ff <= lhd_pkg::LINE_NTSC;
    end else if (cfg_ff[lhd_pkg::CFG_TVS_BIT]) begin
      line_ff <= lhd_pkg::LINE_PAL; // [RL8]
    end else begin
      line_ff <= lhd_pkg::LINE_NTSC;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Display register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      disp_ff <= lhd_pkg::DISP_RST;
    end else if (data_take && (sel_ff == lhd_pkg::REG_DISP)) begin
      disp_ff <= rx_byte; // [RL9]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Horizontal position register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hpos_ff <= lhd_pkg::HPOS_RST;
    end else if (data_take && (sel_ff == lhd_pkg::REG_HPOS)) begin
      hpos_ff <= rx_byte; // [RL10] [RL11]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Text position register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tpos_ff <= lhd_pkg::TPOS_RST;
    end else if (data_take && (sel_ff == lhd_pkg::REG_TPOS)) begin
      tpos_ff <= rx_byte; // [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Packet filter register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      filt_ff <= lhd_pkg::FILT_RST;
    end else if (data_take && (sel_ff == lhd_pkg::REG_FILT)) begin
      filt_ff <= rx_byte; // [RL13] [RL15]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      filt_seen_ff <= 1'b0;
    end else if (data_take && (sel_ff == lhd_pkg::REG_FILT)) begin
      filt_seen_ff <= 1'b1; // [RL16]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      class_en_ff <= 8'h00;
    end else begin
      class_en_ff <= filt_seen_ff ? filt_ff : 8'h00; // [RL14] [RL16]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt mask register and request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      imsk_ff <= lhd_pkg::IMSK_RST;
    end else if (data_take && (sel_ff == lhd_pkg::REG_IMSK)) begin
      imsk_ff <= rx_byte; // [RL17]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_events & imsk_ff); // [RL17]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Serial status byte
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= 8'h00;
      status_ff[lhd_pkg::SS_RDY_BIT] <= ready; // [RL20]
      status_ff[lhd_pkg::SS_IRQ_BIT] <= irq_ff;
      status_ff[lhd_pkg::SS_FLD_BIT] <= field_indicator; // [RL20]
      status_ff[lhd_pkg::SS_LOCK_BIT] <= video_locked; // [RL20]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output fields
  assign serial_status = status_ff;
  assign irq_request = irq_ff;
  assign display_mode = mode_ff;
  assign xds_graze_view = (mode_ff == lhd_pkg::MODE_GRAZE);
  assign xds_alt_view = (mode_ff == lhd_pkg::MODE_ALT);
  assign decoder_on = dec_on_ff;
  assign erase_timer_on = timer_on_ff;
  assign tv_standard_select = cfg_ff[lhd_pkg::CFG_TVS_BIT];
  assign mono_select = cfg_ff[lhd_pkg::CFG_MONO_BIT];
  assign vertical_lock_source = cfg_ff[lhd_pkg::CFG_VLK_BIT];
  assign horizontal_lock_source = cfg_ff[lhd_pkg::CFG_HLK_BIT];
  assign vbi_line = line_ff;
  assign drop_shadow = disp_ff[lhd_pkg::DISP_SHADOW_BIT];
  assign rows_15_lines = disp_ff[lhd_pkg::DISP_15L_BIT];
  assign enhanced_caption_mode = !disp_ff[lhd_pkg::DISP_ENH_OFF_BIT]; // [RL9]
  assign box_position = hpos_ff[6:0]; // [RL10]
  assign box_blue = hpos_ff[lhd_pkg::HPOS_BLUE_BIT]; // [RL11]
  assign text_base_row = tpos_ff[7:4]; // [RL12]
  assign text_row_count = tpos_ff[3:0]; // [RL12]
  assign xds_class_enable = class_en_ff;
  assign xds_recovery_on = |class_en_ff; // [RL13]
  assign int_mask = imsk_ff;
  assign last_command = last_cmd_ff;
endmodule

// ### test/lhd_decoder_monitor.sv
// Checker of the host command decoder ports
`timescale 1ns/1ps
module lhd_decoder_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_stop,
  input wire logic [7:0] rx_byte,
  input wire logic rx_ack,
  input wire logic ready_flag,
  input wire lhd_pkg::lhd_mode_t display_mode,
  input wire logic xds_graze_view,
  input wire logic xds_alt_view,
  input wire logic erase_timer_on,
  input wire logic tv_standard_select,
  input wire logic mono_select,
  input wire logic vertical_lock_source,
  input wire logic horizontal_lock_source,
  input wire logic [4:0] vbi_line,
  input wire logic [6:0] box_position,
  input wire logic box_blue,
  input wire logic [3:0] text_base_row,
  input wire logic [3:0] text_row_count,
  input wire logic [7:0] xds_class_enable
);
  logic pend_ff;
  logic [7:0] sel_ff;
  logic cmd_acc;
  logic dat_acc;
  assign cmd_acc = rx_ack && !rx_first && !pend_ff;
  assign dat_acc = rx_ack && !rx_first && pend_ff;
  // Select byte of a pending two-byte write
  always_ff @(posedge clock) begin
    if (sys_rst || rx_stop || (rx_valid && rx_first)) begin
      pend_ff <= 1'b0;
    end else if (cmd_acc) begin
      pend_ff <= (rx_byte[7:3] == 5'h18);
      sel_ff <= rx_byte;
    end else if (dat_acc) begin
      pend_ff <= 1'b0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  property p_addr;
    rx_valid && rx_first && rx_byte == 8'h28 |-> rx_ack;
  endproperty
  a_addr: assert property (p_addr) else $error("address not acknowledged");
  property p_graze;
    cmd_acc && (rx_byte == 8'h23 || rx_byte == 8'h27) |=> xds_graze_view && !xds_alt_view;
  endproperty
  a_graze: assert property (p_graze) else $error("graze view not set");
  property p_alt;
    cmd_acc && (rx_byte == 8'h21 || rx_byte == 8'h25) |=> xds_alt_view && !xds_graze_view;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate view not set");
  property p_tmr;
    cmd_acc && rx_byte == 8'h20 |=> erase_timer_on && $stable(display_mode);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer on wrong");
  property p_busy;
    cmd_acc || dat_acc |=> !ready_flag [*4] ##1 ready_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("ready timing wrong");
  property p_tpos;
    dat_acc && sel_ff == 8'hC3 |=> {text_base_row, text_row_count} == $past(rx_byte);
  endproperty
  a_tpos: assert property (p_tpos) else $error("text position wrong");
  property p_hpos;
    dat_acc && sel_ff == 8'hC2 |=> {box_blue, box_position} == $past(rx_byte);
  endproperty
  a_hpos: assert property (p_hpos) else $error("box position wrong");
  property p_cfg;
    dat_acc && sel_ff == 8'hC0 |=> {4'h0, horizontal_lock_source, vertical_lock_source,
      mono_select, tv_standard_select} == ($past(rx_byte) & 8'h0F)
      ##1 vbi_line == (tv_standard_select ? 5'h16 : 5'h15);
  endproperty
  a_cfg: assert property (p_cfg) else $error("configuration wrong");
  property p_filt;
    dat_acc && sel_ff == 8'hC5 |=> ##1 xds_class_enable == $past(rx_byte, 2);
  endproperty
  a_filt: assert property (p_filt) else $error("filter wrong");
endmodule
bind lhd_decoder lhd_decoder_monitor lhd_decoder_monitor_i (.*);

// ### test/lhd_host_model.sv
// Host master model that feeds bytes to the decoder
`timescale 1ns/1ps
module lhd_host_model (
  input wire logic clock,
  input wire logic ready_flag,
  input wire logic rx_ack,
  output logic rx_valid,
  output logic rx_first,
  output logic rx_stop,
  output logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_stop = 1'b0;
    rx_byte = 8'hA5;
  end
  // One byte for one cycle, polling ready unless told not to
  task automatic put(input logic first, input logic poll, input logic [7:0] b,
    output logic ack);
    int n;
    n = 0;
    @(negedge clock);
    while (poll && ready_flag !== 1'b1 && n < 50) begin
      n++;
      @(negedge clock);
    end
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_first <= first;
    rx_byte <= b;
    @(negedge clock);
    ack = rx_ack;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic stop();
    @(posedge clock);
    rx_stop <= 1'b1;
    @(posedge clock);
    rx_stop <= 1'b0;
  endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench of the host command decoder
`timescale 1ns/1ps
module tb_top;
  logic clock, sys_rst, rx_valid, rx_first, rx_stop, rx_ack, ready_flag, a;
  logic [7:0] rx_byte, serial_status, irq_events, int_mask, last_command, xds_class_enable;
  logic field_indicator, video_locked, caption_data_in, irq_request, xds_graze_view;
  logic xds_alt_view, decoder_on, erase_timer_on, caption_erase, tv_standard_select;
  logic mono_select, vertical_lock_source, horizontal_lock_source, drop_shadow, box_blue;
  logic rows_15_lines, enhanced_caption_mode, xds_recovery_on;
  logic [4:0] vbi_line;
  logic [6:0] box_position;
  logic [3:0] text_base_row, text_row_count;
  lhd_pkg::lhd_mode_t display_mode, mode;
  logic [7:0] cfg = 8'h00, disp = 8'hC0, hpos = 8'h26, tpos = 8'hFF, filt = 8'h00;
  logic [7:0] imsk = 8'h00;
  logic tmr = 1'b0;
  logic dec = 1'b0;
  logic [7:0] lastc = 8'h00;
  int err_count = 0, checked = 0, cyc = 0;
  localparam logic [15:0] TBL[19] = '{16'hC002, 16'hC00C, 16'hC001, 16'hC000, 16'hC1C3,
    16'hC1E0, 16'hC1C0, 16'hC21D, 16'hC229, 16'hC2A6, 16'hC226, 16'hC3BA, 16'hC541,
    16'hC528, 16'hC59E, 16'hC51F, 16'hC500, 16'hC700, 16'hC455};
  localparam logic [7:0] SELS[6] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC5, 8'hC7};
  lhd_decoder #(.ERASE_CYCLES(50)) lhd_decoder_i (.*);
  lhd_host_model lhd_host_model_i (.*);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic lhd_pkg::lhd_mode_t exp_mode(lhd_pkg::lhd_mode_t m, logic [7:0] b);
    if (b[7:4] == 4'h1) return b[2] ? lhd_pkg::MODE_CAPTION : lhd_pkg::MODE_TEXT;
    if (b[7:3] == 5'h04 && b[0]) return b[1] ? lhd_pkg::MODE_GRAZE : lhd_pkg::MODE_ALT;
    return m;
  endfunction
  task automatic settle();
    logic q;
    repeat (6) @(posedge clock);
    @(negedge clock);
    q = |(irq_events & imsk);
    check("cfg", {4'h0, horizontal_lock_source, vertical_lock_source, mono_select,
      tv_standard_select}, cfg & 8'h0F);
    check("vbi", {3'h0, vbi_line}, cfg[0] ? 8'h16 : 8'h15);
    check("disp", {5'h0, enhanced_caption_mode, rows_15_lines, drop_shadow},
      {5'h0, !disp[5], disp[1:0]});
    check("hpos", {box_blue, box_position}, hpos);
    check("tpos", {text_base_row, text_row_count}, tpos);
    check("filt", xds_class_enable, filt);
    check("mask", int_mask, imsk);
    check("irq", {7'h0, irq_request}, {7'h0, q});
    check("status", serial_status, {4'h8, q, 1'b0, field_indicator, video_locked});
    check("mode", {6'h0, display_mode}, {6'h0, mode});
    check("timer", {7'h0, erase_timer_on}, {7'h0, tmr});
    check("dec", {7'h0, decoder_on}, {7'h0, dec});
    check("last", last_command, lastc);
    check("recov", {7'h0, xds_recovery_on}, {7'h0, |filt});
  endtask
  task automatic put_chk(input logic f, input logic p, input logic [7:0] b, input logic e);
    lhd_host_model_i.put(f, p, b, a);
    check("ack", {7'h0, a}, {7'h0, e});
  endtask
  task automatic cmd(input logic [7:0] b);
    put_chk(1'b0, 1'b1, b, 1'b1);
    mode = exp_mode(mode, b);
    lastc = b;
    if (b[7:4] == 4'h1) dec = b[0];
    if (b[7:3] == 5'h04) tmr = !b[2];
    settle();
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] v);
    @(posedge clock);
    irq_events <= 8'($urandom);
    field_indicator <= 1'($urandom);
    video_locked <= 1'($urandom);
    put_chk(1'b0, 1'b1, s, 1'b1);
    put_chk(1'b0, 1'b1, v, 1'b1);
    lastc = s;
    case (s)
      8'hC0: cfg = v;
      8'hC1: disp = v;
      8'hC2: hpos = v;
      8'hC3: tpos = v;
      8'hC5: filt = v;
      8'hC7: imsk = v;
      default: ;
    endcase
    settle();
  endtask
  task automatic ewin(input logic every, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 120; i++) begin
      @(posedge clock);
      caption_data_in <= (i == 0) || (every && i % 20 == 0);
      @(negedge clock);
      n = n + 8'(caption_erase);
    end
    check("erase", n, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    caption_data_in = 1'b0;
    irq_events = 8'h00;
    field_indicator = 1'b1;
    video_locked = 1'b1;
    mode = lhd_pkg::MODE_CAPTION;
    void'($urandom(56047));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    put_chk(1'b0, 1'b1, 8'h17, 1'b0);
    put_chk(1'b1, 1'b0, 8'h3A, 1'b0);
    put_chk(1'b1, 1'b0, 8'h28, 1'b1);
    put_chk(1'b0, 1'b1, 8'hC3, 1'b1);
    put_chk(1'b0, 1'b0, 8'hBA, 1'b0);
    put_chk(1'b0, 1'b1, 8'hBA, 1'b1);
    tpos = 8'hBA;
    lastc = 8'hC3;
    settle();
    put_chk(1'b0, 1'b1, 8'hC3, 1'b1);
    lhd_host_model_i.stop();
    put_chk(1'b0, 1'b1, 8'h55, 1'b0);
    put_chk(1'b1, 1'b0, 8'h29, 1'b1);
    put_chk(1'b0, 1'b1, 8'h17, 1'b0);
    put_chk(1'b1, 1'b0, 8'h28, 1'b1);
    for (int k = 0; k < 8; k++) cmd(8'(8'h20 + k));
    cmd(8'h13);
    cmd(8'h17);
    for (int i = 0; i < 19; i++) wr(TBL[i][15:8], TBL[i][7:0]);
    repeat (24) wr(SELS[$urandom % 6], 8'($urandom));
    cmd(8'h20);
    ewin(1'b0, 8'h02);
    ewin(1'b1, 8'h00);
    cmd(8'h13);
    ewin(1'b0, 8'h00);
    cmd(8'h23);
    ewin(1'b0, 8'h02);
    cmd(8'h24);
    ewin(1'b0, 8'h00);
    finish_test();
  end
endmodule
